// file: design/odx_pkg.sv
`default_nettype none
package odx_pkg;
    // Operation codes presented to the execution unit.
    typedef enum logic [4:0] {
        OP_NONE       = 5'b0_0000,
        OP_COPY_TO_SEG   = 5'b0_0001,
        OP_COPY_FROM_SEG = 5'b0_0010,
        OP_TABLE_LOOKUP  = 5'b0_0011,
        OP_LOAD_FAR_DATA_SEG  = 5'b0_0100,
        OP_LOAD_FAR_EXTRA_SEG = 5'b0_0101,
        OP_UNSIGNED_PRODUCT = 5'b0_0110,
        OP_SIGNED_PRODUCT   = 5'b0_0111,
        OP_UNSIGNED_QUOTIENT = 5'b0_1000,
        OP_SIGNED_QUOTIENT   = 5'b0_1001,
        OP_ASCII_ADJ_PRODUCT = 5'b0_1010,
        OP_ASCII_ADJ_QUOTIENT = 5'b0_1011,
        OP_BYTE_TO_WORD  = 5'b0_1100,
        OP_WORD_TO_DWORD = 5'b0_1101,
        OP_ADD           = 5'b0_1110,
        OP_ADD_CARRY     = 5'b0_1111,
        OP_DIFFERENCE    = 5'b1_0000,
        OP_BORROW_DIFFERENCE = 5'b1_0001,
        OP_ASCII_ADJ_DIFFERENCE = 5'b1_0010,
        OP_DECIMAL_ADJ_DIFFERENCE = 5'b1_0011,
        OP_ILLEGAL       = 5'b1_1111
    } odx_op_type;

    // Operand source selects.
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_REG  = 2'b01,
        SRC_RM   = 2'b10,
        SRC_IMM  = 2'b11
    } odx_src_type;

    // First- and second-byte codes and masks.
    localparam logic [7:0] OPC_COPY_TO_SEG    = 8'h8E;
    localparam logic [7:0] OPC_COPY_FROM_SEG  = 8'h8C;
    localparam logic [7:0] OPC_TABLE_LOOKUP   = 8'hD7;
    localparam logic [7:0] OPC_LOAD_FAR_DATA_SEG  = 8'hC5;
    localparam logic [7:0] OPC_LOAD_FAR_EXTRA_SEG = 8'hC4;
    localparam logic [7:0] OPC_GROUP_MULDIV   = 8'hF6;
    localparam logic [7:0] OPC_ASCII_PRODUCT  = 8'hD4;
    localparam logic [7:0] OPC_ASCII_QUOTIENT = 8'hD5;
    localparam logic [7:0] OPC_ASCII_BASE     = 8'h0A;
    localparam logic [7:0] OPC_BYTE_TO_WORD   = 8'h98;
    localparam logic [7:0] OPC_WORD_TO_DWORD  = 8'h99;
    localparam logic [7:0] OPC_ADD_REG        = 8'h00;
    localparam logic [7:0] OPC_ADD_CARRY_REG  = 8'h10;
    localparam logic [7:0] OPC_DIFF_REG       = 8'h28;
    localparam logic [7:0] OPC_BORROW_REG     = 8'h18;
    localparam logic [7:0] OPC_GROUP_IMM      = 8'h80;
    localparam logic [7:0] OPC_ADD_ACC        = 8'h04;
    localparam logic [7:0] OPC_ADD_CARRY_ACC  = 8'h14;
    localparam logic [7:0] OPC_DIFF_ACC       = 8'h2C;
    localparam logic [7:0] OPC_ASCII_DIFF     = 8'h3F;
    localparam logic [7:0] OPC_DECIMAL_DIFF   = 8'h2F;
    localparam logic [7:0] MASK_DW            = 8'hFC;
    localparam logic [7:0] MASK_W             = 8'hFE;

    // Addressing-byte middle field codes.
    localparam logic [2:0] MID_ADD      = 3'b000;
    localparam logic [2:0] MID_CARRY    = 3'b010;
    localparam logic [2:0] MID_BORROW   = 3'b011;
    localparam logic [2:0] MID_UPRODUCT = 3'b100;
    localparam logic [2:0] MID_DIFF     = 3'b101;
    localparam logic [2:0] MID_SPRODUCT = 3'b101;
    localparam logic [2:0] MID_UQUOT    = 3'b110;
    localparam logic [2:0] MID_SQUOT    = 3'b111;

    // Field positions.
    localparam int W_BIT = 0;
    localparam int D_BIT = 1;
    localparam int S_BIT = 1;
    localparam int SEG_MSB = 4;
endpackage
`default_nettype wire

// file: design/odx_first_byte.sv
`default_nettype none
// Classifies a first opcode byte: what follows it and which operation it starts.
module odx_first_byte
(
    input  wire logic [7:0]          opcode,
    output var  logic                needs_modrm,
    output var  logic                acc_imm,
    output var  logic                two_byte_fixed,
    output var  logic                single,
    output var  odx_pkg::odx_op_type op
);
    import odx_pkg::*;
    // Pure decode of the first byte; the middle field refines grouped forms later.
    always_comb begin
        needs_modrm    = 1'b0;
        acc_imm        = 1'b0;
        two_byte_fixed = 1'b0;
        single         = 1'b0;
        op             = OP_ILLEGAL;
        if (opcode == OPC_COPY_TO_SEG) begin
            needs_modrm = 1'b1;
            op = OP_COPY_TO_SEG;
        end else if (opcode == OPC_COPY_FROM_SEG) begin
            needs_modrm = 1'b1;
            op = OP_COPY_FROM_SEG;
        end else if (opcode == OPC_TABLE_LOOKUP) begin
            single = 1'b1;
            op = OP_TABLE_LOOKUP;
        end else if (opcode == OPC_LOAD_FAR_DATA_SEG) begin
            needs_modrm = 1'b1;
            op = OP_LOAD_FAR_DATA_SEG;
        end else if (opcode == OPC_LOAD_FAR_EXTRA_SEG) begin
            needs_modrm = 1'b1;
            op = OP_LOAD_FAR_EXTRA_SEG;
        end else if ((opcode & MASK_W) == OPC_GROUP_MULDIV) begin
            needs_modrm = 1'b1;
            op = OP_NONE;
        end else if (opcode == OPC_ASCII_PRODUCT) begin
            two_byte_fixed = 1'b1;
            op = OP_ASCII_ADJ_PRODUCT;
        end else if (opcode == OPC_ASCII_QUOTIENT) begin
            two_byte_fixed = 1'b1;
            op = OP_ASCII_ADJ_QUOTIENT;
        end else if (opcode == OPC_BYTE_TO_WORD) begin
            single = 1'b1;
            op = OP_BYTE_TO_WORD;
        end else if (opcode == OPC_WORD_TO_DWORD) begin
            single = 1'b1;
            op = OP_WORD_TO_DWORD;
        end else if ((opcode & MASK_DW) == OPC_ADD_CARRY_REG) begin
            needs_modrm = 1'b1;
            op = OP_ADD_CARRY;
        end else if ((opcode & MASK_DW) == OPC_ADD_REG) begin
            needs_modrm = 1'b1;
            op = OP_ADD;
        end else if ((opcode & MASK_DW) == OPC_DIFF_REG) begin
            needs_modrm = 1'b1;
            op = OP_DIFFERENCE;
        end else if ((opcode & MASK_DW) == OPC_BORROW_REG) begin
            needs_modrm = 1'b1;
            op = OP_BORROW_DIFFERENCE;
        end else if ((opcode & MASK_DW) == OPC_GROUP_IMM) begin
            needs_modrm = 1'b1;
            op = OP_NONE;
        end else if ((opcode & MASK_W) == OPC_ADD_ACC) begin
            acc_imm = 1'b1;
            op = OP_ADD;
        end else if ((opcode & MASK_W) == OPC_ADD_CARRY_ACC) begin
            acc_imm = 1'b1;
            op = OP_ADD_CARRY;
        end else if ((opcode & MASK_W) == OPC_DIFF_ACC) begin
            acc_imm = 1'b1;
            op = OP_DIFFERENCE;
        end else if (opcode == OPC_ASCII_DIFF) begin
            single = 1'b1;
            op = OP_ASCII_ADJ_DIFFERENCE;
        end else if (opcode == OPC_DECIMAL_DIFF) begin
            single = 1'b1;
            op = OP_DECIMAL_ADJ_DIFFERENCE;
        end
    end
endmodule
`default_nettype wire

// file: design/odx_decoder.sv
`default_nettype none
// Overview of operation
// - 8E plus segment field copies into segment.
// - 8C copies segment register to operand.
// - D7 is single-byte table lookup.
// - C5 loads far pointer with data segment.
// - C4 loads far pointer with extra segment.
// - F6/F7 field 100/101 unsigned/signed product.
// - F6/F7 field 110/111 unsigned/signed quotient.
// - D4 0A is ASCII adjust after product.
// - D5 0A is ASCII adjust before quotient.
// - 98 sign-extends low byte to word.
// - 99 sign-extends word into doubleword.
// - Add-with-carry register, immediate, accumulator forms.
// - Add immediate forms; accumulator high byte if word.
// - Subtract register, immediate, accumulator forms.
// - Borrow subtract register and immediate forms.
// - 3F is ASCII adjust after difference.
// - 2F is decimal adjust after difference.
module odx_decoder
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 byte_valid,
    input  wire logic [7:0]           byte_data,
    output var  logic                 dec_valid,
    output var  odx_pkg::odx_op_type  dec_op,
    output var  logic                 dec_word,
    output var  logic                 dec_reg_is_dest,
    output var  logic [1:0]           dec_mod,
    output var  logic [2:0]           dec_reg,
    output var  logic [2:0]           dec_rm,
    output var  odx_pkg::odx_src_type dec_src,
    output var  logic [15:0]          dec_disp,
    output var  logic [15:0]          dec_imm,
    output var  logic                 dec_error
);
    import odx_pkg::*;

    typedef enum logic [2:0] {
        ST_FIRST  = 3'b000,
        ST_MODRM  = 3'b001,
        ST_DISP_LO = 3'b010,
        ST_DISP_HI = 3'b011,
        ST_IMM_LO = 3'b100,
        ST_IMM_HI = 3'b101,
        ST_FIXED  = 3'b110
    } odx_state_type;

    typedef struct packed {
        odx_state_type state;
        logic [7:0]    opcode;
        odx_op_type    op;
        logic          word;
        logic          reg_dest;
        logic          sext;
        logic          want_imm;
        logic [1:0]    mode;
        logic [2:0]    regf;
        logic [2:0]    rm;
        odx_src_type   src;
        logic [15:0]   disp;
        logic [15:0]   imm;
        logic          valid;
        logic          error;
    } odx_regs_type;

    odx_regs_type regs_ff;
    odx_regs_type nxt_regs;

    logic       fb_modrm;
    logic       fb_acc;
    logic       fb_fixed;
    logic       fb_single;
    odx_op_type fb_op;

    // First-byte classifier.
    odx_first_byte u_first (
        .opcode         (byte_data),
        .needs_modrm    (fb_modrm),
        .acc_imm        (fb_acc),
        .two_byte_fixed (fb_fixed),
        .single         (fb_single),
        .op             (fb_op)
    );

    // Number of displacement bytes an addressing byte calls for.
    function automatic logic [1:0] disp_bytes(input logic [7:0] m);
        if (m[7:6] == 2'b01) begin
            disp_bytes = 2'd1;
        end else if (m[7:6] == 2'b10 || (m[7:6] == 2'b00 && m[2:0] == 3'b110)) begin
            disp_bytes = 2'd2;
        end else begin
            disp_bytes = 2'd0;
        end
    endfunction

    // State after the addressing and displacement bytes are done.
    function automatic odx_state_type after_disp(input logic want);
        after_disp = want ? ST_IMM_LO : ST_FIRST;
    endfunction

    // Decode step. One byte is consumed per valid cycle; the result pulses once.
    always_comb begin
        nxt_regs = regs_ff;
        nxt_regs.valid = 1'b0;
        nxt_regs.error = 1'b0;
        if (byte_valid) begin
            case (regs_ff.state)
                ST_FIRST: begin
                    nxt_regs.opcode = byte_data;
                    nxt_regs.op = fb_op;
                    nxt_regs.word = byte_data[W_BIT];
                    nxt_regs.reg_dest = byte_data[D_BIT];
                    nxt_regs.sext = 1'b0;
                    nxt_regs.want_imm = 1'b0;
                    nxt_regs.mode = 2'b00;
                    nxt_regs.regf = 3'b000;
                    nxt_regs.rm = 3'b000;
                    nxt_regs.disp = 16'h0000;
                    nxt_regs.imm = 16'h0000;
                    nxt_regs.src = SRC_NONE;
                    if (fb_single) begin
                        // Single-byte operations work on the accumulator byte or word implicitly.
                        nxt_regs.word = (fb_op == OP_WORD_TO_DWORD);
                        nxt_regs.reg_dest = 1'b0;
                        nxt_regs.valid = 1'b1;
                    end else if (fb_fixed) begin
                        nxt_regs.word = 1'b0;
                        nxt_regs.reg_dest = 1'b0;
                        nxt_regs.state = ST_FIXED;
                    end else if (fb_acc) begin
                        nxt_regs.reg_dest = 1'b1;
                        nxt_regs.src = SRC_IMM;
                        nxt_regs.state = ST_IMM_LO;
                    end else if (fb_modrm) begin
                        if (byte_data == OPC_COPY_TO_SEG) begin
                            nxt_regs.word = 1'b1;
                            nxt_regs.reg_dest = 1'b1;
                        end else if (byte_data == OPC_COPY_FROM_SEG) begin
                            nxt_regs.word = 1'b1;
                            nxt_regs.reg_dest = 1'b0;
                        end else if (byte_data == OPC_LOAD_FAR_DATA_SEG || byte_data == OPC_LOAD_FAR_EXTRA_SEG) begin
                            nxt_regs.word = 1'b1;
                            nxt_regs.reg_dest = 1'b1;
                        end else if ((byte_data & MASK_DW) == OPC_GROUP_IMM) begin
                            nxt_regs.sext = byte_data[S_BIT];
                            nxt_regs.reg_dest = 1'b0;
                            nxt_regs.want_imm = 1'b1;
                        end else if ((byte_data & MASK_W) == OPC_GROUP_MULDIV) begin
                            nxt_regs.reg_dest = 1'b0;
                        end
                        nxt_regs.state = ST_MODRM;
                    end else begin
                        nxt_regs.error = 1'b1;
                    end
                end
                ST_MODRM: begin
                    nxt_regs.mode = byte_data[7:6];
                    nxt_regs.regf = byte_data[5:3];
                    nxt_regs.rm = byte_data[2:0];
                    nxt_regs.src = regs_ff.want_imm ? SRC_IMM : (regs_ff.reg_dest ? SRC_RM : SRC_REG);
                    if (regs_ff.opcode == OPC_COPY_TO_SEG || regs_ff.opcode == OPC_COPY_FROM_SEG) begin
                        // Only four segment registers exist; a set top bit is refused.
                        if (byte_data[5]) begin
                            nxt_regs.op = OP_ILLEGAL;
                        end
                    end else if ((regs_ff.opcode & MASK_W) == OPC_GROUP_MULDIV) begin
                        if (byte_data[5:3] == MID_UPRODUCT) begin
                            nxt_regs.op = OP_UNSIGNED_PRODUCT;
                        end else if (byte_data[5:3] == MID_SPRODUCT) begin
                            nxt_regs.op = OP_SIGNED_PRODUCT;
                        end else if (byte_data[5:3] == MID_UQUOT) begin
                            nxt_regs.op = OP_UNSIGNED_QUOTIENT;
                        end else if (byte_data[5:3] == MID_SQUOT) begin
                            nxt_regs.op = OP_SIGNED_QUOTIENT;
                        end else begin
                            nxt_regs.op = OP_ILLEGAL;
                        end
                    end else if ((regs_ff.opcode & MASK_DW) == OPC_GROUP_IMM) begin
                        if (byte_data[5:3] == MID_ADD) begin
                            nxt_regs.op = OP_ADD;
                        end else if (byte_data[5:3] == MID_CARRY) begin
                            nxt_regs.op = OP_ADD_CARRY;
                        end else if (byte_data[5:3] == MID_BORROW) begin
                            nxt_regs.op = OP_BORROW_DIFFERENCE;
                        end else if (byte_data[5:3] == MID_DIFF) begin
                            nxt_regs.op = OP_DIFFERENCE;
                        end else begin
                            nxt_regs.op = OP_ILLEGAL;
                        end
                    end
                    if (disp_bytes(byte_data) != 2'd0) begin
                        nxt_regs.state = ST_DISP_LO;
                    end else if (regs_ff.want_imm) begin
                        nxt_regs.state = ST_IMM_LO;
                    end else begin
                        nxt_regs.state = ST_FIRST;
                        nxt_regs.valid = 1'b1;
                    end
                end
                ST_DISP_LO: begin
                    // A one-byte displacement is sign-extended to a word.
                    nxt_regs.disp = {{8{byte_data[7]}}, byte_data};
                    if (regs_ff.mode != 2'b01) begin
                        nxt_regs.state = ST_DISP_HI;
                    end else begin
                        nxt_regs.state = after_disp(regs_ff.want_imm);
                        nxt_regs.valid = !regs_ff.want_imm;
                    end
                end
                ST_DISP_HI: begin
                    nxt_regs.disp = {byte_data, regs_ff.disp[7:0]};
                    nxt_regs.state = after_disp(regs_ff.want_imm);
                    nxt_regs.valid = !regs_ff.want_imm;
                end
                ST_IMM_LO: begin
                    // Sign-extended byte immediates finish here, as do byte-sized ones.
                    nxt_regs.imm = {{8{byte_data[7] & regs_ff.sext & regs_ff.word}}, byte_data};
                    if (regs_ff.word && !regs_ff.sext) begin
                        nxt_regs.state = ST_IMM_HI;
                    end else begin
                        nxt_regs.state = ST_FIRST;
                        nxt_regs.valid = 1'b1;
                    end
                end
                ST_IMM_HI: begin
                    nxt_regs.imm = {byte_data, regs_ff.imm[7:0]};
                    nxt_regs.state = ST_FIRST;
                    nxt_regs.valid = 1'b1;
                end
                ST_FIXED: begin
                    // Only the documented base byte is accepted as the second byte.
                    nxt_regs.state = ST_FIRST;
                    if (byte_data == OPC_ASCII_BASE) begin
                        nxt_regs.valid = 1'b1;
                    end else begin
                        nxt_regs.op = OP_ILLEGAL;
                        nxt_regs.valid = 1'b1;
                    end
                end
                default: begin
                    nxt_regs.state = ST_FIRST;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            regs_ff <= '0;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    assign dec_valid       = regs_ff.valid;
    assign dec_op          = regs_ff.op;
    assign dec_word        = regs_ff.word;
    assign dec_reg_is_dest = regs_ff.reg_dest;
    assign dec_mod         = regs_ff.mode;
    assign dec_reg         = regs_ff.regf;
    assign dec_rm          = regs_ff.rm;
    assign dec_src         = regs_ff.src;
    assign dec_disp        = regs_ff.disp;
    assign dec_imm         = regs_ff.imm;
    assign dec_error       = regs_ff.error;

    property p_single_byte;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_FIRST && byte_valid && byte_data == OPC_TABLE_LOOKUP)
            |=> (dec_valid && dec_op == OP_TABLE_LOOKUP && !dec_word);
    endproperty
    a_single_byte: assert property (p_single_byte) else $error("table lookup not decoded");

    property p_word_to_dword;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_FIRST && byte_valid && byte_data == OPC_WORD_TO_DWORD)
            |=> (dec_valid && dec_op == OP_WORD_TO_DWORD && dec_word);
    endproperty
    a_word_to_dword: assert property (p_word_to_dword) else $error("word to doubleword not decoded");

    property p_byte_to_word;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_FIRST && byte_valid && byte_data == OPC_BYTE_TO_WORD)
            |=> (dec_valid && dec_op == OP_BYTE_TO_WORD && !dec_word);
    endproperty
    a_byte_to_word: assert property (p_byte_to_word) else $error("byte to word not decoded");

    property p_ascii_product;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_FIRST && byte_valid && byte_data == OPC_ASCII_PRODUCT)
            ##1 (byte_valid && byte_data == OPC_ASCII_BASE) |=> (dec_valid && dec_op == OP_ASCII_ADJ_PRODUCT);
    endproperty
    a_ascii_product: assert property (p_ascii_product) else $error("ascii adjust after product not decoded");

    property p_muldiv;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_MODRM && byte_valid && (regs_ff.opcode & MASK_W) == OPC_GROUP_MULDIV
            && byte_data[5:3] == MID_SQUOT) |=> (dec_op == OP_SIGNED_QUOTIENT);
    endproperty
    a_muldiv: assert property (p_muldiv) else $error("signed quotient not selected");

    property p_product;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_MODRM && byte_valid && (regs_ff.opcode & MASK_W) == OPC_GROUP_MULDIV
            && byte_data[5:3] == MID_UPRODUCT) |=> (dec_op == OP_UNSIGNED_PRODUCT);
    endproperty
    a_product: assert property (p_product) else $error("unsigned product not selected");

    property p_word_bit;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_FIRST && byte_valid && fb_modrm && (byte_data & MASK_DW) == OPC_ADD_CARRY_REG)
            |=> (dec_word == $past(byte_data[W_BIT]) && dec_reg_is_dest == $past(byte_data[D_BIT]));
    endproperty
    a_word_bit: assert property (p_word_bit) else $error("word or direction bit lost");

    property p_sext_imm;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_IMM_LO && byte_valid && regs_ff.sext && regs_ff.word)
            |=> (dec_valid && dec_imm == {{8{$past(byte_data[7])}}, $past(byte_data)});
    endproperty
    a_sext_imm: assert property (p_sext_imm) else $error("sign-extended immediate wrong");

    // A segment field beyond the four segment registers must never decode as a copy into a segment.
    property p_seg_refuse;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_MODRM && byte_valid && regs_ff.opcode == OPC_COPY_TO_SEG && byte_data[5])
            |=> (dec_op == OP_ILLEGAL);
    endproperty
    a_seg_refuse: assert property (p_seg_refuse) else $error("bad segment field not refused");

    property p_acc_byte_imm;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_FIRST && byte_valid && (byte_data & MASK_W) == OPC_ADD_ACC && !byte_data[W_BIT])
            ##1 byte_valid |=> (dec_valid && dec_op == OP_ADD && !dec_word);
    endproperty
    a_acc_byte_imm: assert property (p_acc_byte_imm) else $error("byte immediate add not decoded");

    property p_signed_product;
        @(posedge sys_clk) disable iff (reset)
        (regs_ff.state == ST_MODRM && byte_valid && (regs_ff.opcode & MASK_W) == OPC_GROUP_MULDIV
            && byte_data[5:3] == MID_SPRODUCT) |=> (dec_op == OP_SIGNED_PRODUCT);
    endproperty
    a_signed_product: assert property (p_signed_product) else $error("signed product not selected");
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import odx_pkg::*;
    logic        sys_clk;
    logic        reset;
    logic        byte_valid;
    logic [7:0]  byte_data;
    logic        dec_valid;
    odx_op_type  dec_op;
    logic        dec_word;
    logic        dec_reg_is_dest;
    logic [2:0]  dec_reg;
    logic [1:0]  dec_mod;
    logic [2:0]  dec_rm;
    odx_src_type dec_src;
    logic [15:0] dec_disp;
    logic [15:0] dec_imm;
    logic        dec_error;
    logic        got_err;
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;

    odx_decoder dut (.sys_clk(sys_clk), .reset(reset), .byte_valid(byte_valid), .byte_data(byte_data),
        .dec_valid(dec_valid), .dec_op(dec_op), .dec_word(dec_word), .dec_reg_is_dest(dec_reg_is_dest),
        .dec_mod(dec_mod), .dec_reg(dec_reg), .dec_rm(dec_rm), .dec_src(dec_src), .dec_disp(dec_disp),
        .dec_imm(dec_imm),
        .dec_error(dec_error));

    // Free-running 100 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // A hung decode must not stall the run forever, so a cycle ceiling ends it.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        if (bad_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_dec(input odx_op_type op, input logic word);
        chk_v(16'(dec_op), 16'(op));
        chk_v({15'h0, dec_word}, {15'h0, word});
    endtask

    // Bytes go in on falling edges; the wait for the answer is bounded so a lost pulse shows up.
    task automatic issue(input logic [7:0] q[$]);
        int n;
        foreach (q[i]) begin
            @(negedge sys_clk);
            byte_valid = 1'b1;
            byte_data = q[i];
        end
        @(negedge sys_clk);
        byte_valid = 1'b0;
        for (n = 0; n < 4 && dec_valid !== 1'b1 && dec_error !== 1'b1; n++) @(negedge sys_clk);
        got_err = dec_error;
        chk_v(16'(n < 4), 16'h0001);
    endtask

    task automatic t_seg_far;
        issue('{8'h8E, 8'hD8});
        chk_dec(OP_COPY_TO_SEG, 1'b1);
        chk_v({13'h0, dec_reg}, 16'h0003);
        chk_v({9'h0, dec_src, dec_mod, dec_rm}, 16'h0058);
        issue('{8'h8C, 8'h06, 8'h34, 8'h12});
        chk_dec(OP_COPY_FROM_SEG, 1'b1);
        chk_v({9'h0, dec_src, dec_mod, dec_rm}, 16'h0026);
        chk_v(dec_disp, 16'h1234);
        issue('{8'h8E, 8'hE0});
        chk_v(16'(dec_op), 16'(OP_ILLEGAL));
        issue('{8'hC5, 8'h07});
        chk_v(16'(dec_op), 16'(OP_LOAD_FAR_DATA_SEG));
        issue('{8'hC4, 8'h5E, 8'h80});
        chk_v(16'(dec_op), 16'(OP_LOAD_FAR_EXTRA_SEG));
        chk_v(dec_disp, 16'hFF80);
    endtask

    task automatic t_single;
        logic [7:0] code [5] = '{8'hD7, 8'h98, 8'h99, 8'h3F, 8'h2F};
        odx_op_type ops [5] = '{OP_TABLE_LOOKUP, OP_BYTE_TO_WORD, OP_WORD_TO_DWORD,
                                OP_ASCII_ADJ_DIFFERENCE, OP_DECIMAL_ADJ_DIFFERENCE};
        for (int i = 0; i < 5; i++) begin
            issue('{code[i]});
            chk_dec(ops[i], code[i] == 8'h99);
        end
    endtask

    // Every product and quotient field in both operand sizes.
    task automatic t_muldiv;
        odx_op_type ops [4] = '{OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_UNSIGNED_QUOTIENT, OP_SIGNED_QUOTIENT};
        for (int i = 0; i < 8; i++) begin
            issue('{8'hF6 | 8'(i / 4), 8'hC1 | 8'((4 + i % 4) << 3)});
            chk_dec(ops[i % 4], i >= 4);
        end
        issue('{8'hD4, 8'h0A});
        chk_v(16'(dec_op), 16'(OP_ASCII_ADJ_PRODUCT));
        issue('{8'hD5, 8'h0A});
        chk_v(16'(dec_op), 16'(OP_ASCII_ADJ_QUOTIENT));
        issue('{8'hD5, 8'h0B});
        chk_v(16'(dec_op), 16'(OP_ILLEGAL));
    endtask

    task automatic t_arith;
        issue('{8'h05, 8'h34, 8'h12});
        chk_v(dec_imm, 16'h1234);
        chk_v({9'h0, dec_src, dec_mod, dec_rm}, 16'h0060);
        issue('{8'h04, 8'h7F});
        chk_dec(OP_ADD, 1'b0);
        issue('{8'h83, 8'hC0, 8'hFF});
        chk_v(dec_imm, 16'hFFFF);
        chk_v({9'h0, dec_src, dec_mod, dec_rm}, 16'h0078);
        issue('{8'h83, 8'h46, 8'h10, 8'hFE});
        chk_v(dec_disp, 16'h0010);
        chk_v(dec_imm, 16'hFFFE);
        issue('{8'h01, 8'hC1});
        chk_dec(OP_ADD, 1'b1);
        issue('{8'h81, 8'hD1, 8'h80, 8'hFF});
        chk_dec(OP_ADD_CARRY, 1'b1);
        chk_v(dec_imm, 16'hFF80);
        issue('{8'h15, 8'h00, 8'h80});
        chk_dec(OP_ADD_CARRY, 1'b1);
        issue('{8'h2C, 8'h05});
        chk_dec(OP_DIFFERENCE, 1'b0);
        issue('{8'h80, 8'hE8, 8'h05});
        chk_v(dec_imm, 16'h0005);
        issue('{8'h83, 8'hDB, 8'h01});
        chk_dec(OP_BORROW_DIFFERENCE, 1'b1);
        issue('{8'h13, 8'hC1});
        chk_v({14'h0, dec_reg_is_dest, dec_word}, 16'h0003);
        issue('{8'h28, 8'hC1});
        chk_dec(OP_DIFFERENCE, 1'b0);
        chk_v({15'h0, dec_reg_is_dest}, 16'h0000);
        issue('{8'h1A, 8'h4A, 8'hFE});
        chk_dec(OP_BORROW_DIFFERENCE, 1'b0);
        chk_v(dec_disp, 16'hFFFE);
        issue('{8'hF4});
        chk_v({15'h0, got_err}, 16'h0001);
    endtask

    initial begin
        reset = 1'b1;
        byte_valid = 1'b0;
        byte_data = 8'h00;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        chk_dec(OP_NONE, 1'b0);
        t_seg_far();
        t_single();
        t_muldiv();
        t_arith();
        report_and_stop();
    end
endmodule
`default_nettype wire
